// File: inc/sram_host_pkg.sv
/*
  constants, types and timing counts shared by the host controller for a
  128K x 8 battery-backed asynchronous static memory.
  assumes a single 100 MHz system clock; times are kept in their own units
  and turned into whole clock cycles here.
*/
package sram_host_pkg;

  // bus geometry: 17 address lines select one of 131,072 bytes
  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;
  localparam int MEM_DEPTH = 131072;

  // system clock
  localparam int CLK_PERIOD_NS = 10;

  // device timing, ns (fastest speed grade)
  localparam int ADDRESS_TO_DATA_DELAY_NS = 100;
  localparam int SELECT_TO_DATA_DELAY_NS = 100;
  localparam int GATE_TO_DATA_DELAY_NS = 50;
  localparam int STROBE_TO_FLOAT_DELAY_NS = 35;
  localparam int DESELECT_FLOAT_DELAY_NS = 35;
  localparam int WRITE_PULSE_NS = 75;
  localparam int DATA_SETUP_NS = 40;
  localparam int STROBE_RECOVERY_GAP_NS = 20;

  // supply recovery interval, ms
  localparam int PROTECT_RECOVERY_MS = 125;

  // input synchroniser depth
  localparam int SYNC_STAGES = 2;

  // least time in ns to whole cycles, rounded up, never below one
  function automatic int cyc_min(input int t_ns);
    int c;
    c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : cyc_min

  function automatic int max3(input int a, input int b, input int c);
    int m;
    m = (a > b) ? a : b;
    return (m > c) ? m : c;
  endfunction : max3

  // cycle counts derived from the times above
  localparam int RD_CYC = cyc_min(max3(ADDRESS_TO_DATA_DELAY_NS, SELECT_TO_DATA_DELAY_NS,
                                       GATE_TO_DATA_DELAY_NS));
  localparam int WP_CYC = cyc_min(max3(WRITE_PULSE_NS, DATA_SETUP_NS, 0));
  localparam int GAP_CYC = cyc_min(max3(STROBE_RECOVERY_GAP_NS, DESELECT_FLOAT_DELAY_NS,
                                        STROBE_TO_FLOAT_DELAY_NS));
  localparam int REC_CYC = PROTECT_RECOVERY_MS * (1000000 / CLK_PERIOD_NS);

  // small cycle counter
  localparam int CNT_W = 8;
  typedef logic [CNT_W-1:0] cnt_t;
  // one spare cycle, so the first sync flop never samples right at the access limit
  localparam cnt_t RD_LAST = cnt_t'(RD_CYC + SYNC_STAGES);
  localparam cnt_t WP_LAST = cnt_t'(WP_CYC - 1);
  localparam cnt_t GAP_LAST = cnt_t'(GAP_CYC - 1);

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_RD      = 3'b001,
    ST_WR_SET  = 3'b010,
    ST_WR_PULSE = 3'b011,
    ST_GAP     = 3'b100,
    ST_PROTECT = 3'b101
  } host_state_t;

endpackage : sram_host_pkg

// File: verilog/pin_sync.sv
/*
  two-flop synchroniser for a group of pin inputs.
  assumes the inputs change slowly relative to the clock or are sampled only
  once stable; bits of a bus may land one cycle apart.
*/
`timescale 1ns/10ps
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] q_r;

  // first stage feeds only the second stage
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_r <= '0;
      q_r <= '0;
    end else begin
      meta_r <= d_i;
      q_r <= meta_r;
    end
  end

  assign q_o = q_r;

endmodule : pin_sync

`default_nettype wire

// File: verilog/sram_host.sv
/*
  host controller that drives a 128K x 8 battery-backed asynchronous static
  memory over its address lines, data lines, select, write strobe and gate.
  assumes the memory pins are wired straight to the ports below, the data
  lines are resolved outside from data_oe_o, and a supply monitor gives a
  power-good level; requests come from logic on sys_clk_i.
*/
// Notes on behaviour
// - A write happens while strobe and select are both low, with address stable first.
// - The host holds all address lines unchanged while the write is active.
// - After a write the host keeps the strobe high for the recovery gap before a new cycle.
// - The host keeps the gate high during writes so nobody fights on the data lines.
`timescale 1ns/10ps
`default_nettype none

module sram_host
  import sram_host_pkg::*;
#(
  parameter int RECOVERY_CYCLES = REC_CYC
) (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // user side
  input wire logic req_i,
  input wire logic write_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  output logic ready_o,
  output logic [DATA_W-1:0] rdata_o,
  output logic rvalid_o,
  output logic wdone_o,
  output logic protect_o,
  // memory pins
  input wire logic power_good_i,
  input wire logic [DATA_W-1:0] data_lines_i,
  output logic [DATA_W-1:0] data_lines_o,
  output logic data_oe_o,
  output logic [ADDR_W-1:0] addr_lines_o,
  output logic chip_select_n_o,
  output logic write_strobe_n_o,
  output logic output_gate_n_o
);

  localparam int REC_W = $clog2(RECOVERY_CYCLES + 1);
  localparam logic [REC_W-1:0] REC_LAST = REC_W'(RECOVERY_CYCLES - 1);

  logic [DATA_W-1:0] data_s;
  logic pg_s;

  // pins from outside the clock domain pass two flops first
  pin_sync #(.WIDTH(DATA_W)) u_data_sync (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .d_i(data_lines_i),
    .q_o(data_s)
  );

  pin_sync #(.WIDTH(1)) u_pg_sync (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .d_i(power_good_i),
    .q_o(pg_s)
  );

  host_state_t state_r, state_nxt;
  cnt_t cnt_r, cnt_nxt;
  logic [REC_W-1:0] rec_cnt_r, rec_cnt_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [DATA_W-1:0] wdata_r, wdata_nxt;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  logic data_oe_r, data_oe_nxt;
  logic cs_n_r, cs_n_nxt;
  logic we_n_r, we_n_nxt;
  logic oe_n_r, oe_n_nxt;
  logic ready_r, ready_nxt;
  logic rvalid_r, rvalid_nxt;
  logic wdone_r, wdone_nxt;
  logic protect_r, protect_nxt;

  // sequencer: one access at a time, every pin edge placed on a cycle boundary
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    rec_cnt_nxt = rec_cnt_r;
    addr_nxt = addr_r;
    wdata_nxt = wdata_r;
    rdata_nxt = rdata_r;
    data_oe_nxt = data_oe_r;
    cs_n_nxt = cs_n_r;
    we_n_nxt = we_n_r;
    oe_n_nxt = oe_n_r;
    rvalid_nxt = 1'b0;
    wdone_nxt = 1'b0;
    if (!pg_s) begin
      // supply lost: drop any access at once, pins idle, recovery restarts
      state_nxt = ST_PROTECT;
      cnt_nxt = '0;
      rec_cnt_nxt = '0;
      data_oe_nxt = 1'b0;
      cs_n_nxt = 1'b1;
      we_n_nxt = 1'b1;
      oe_n_nxt = 1'b1;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (req_i && ready_r) begin
            addr_nxt = addr_i;
            cnt_nxt = '0;
            if (write_i) begin
              // address and data settle a cycle before the strobes fall
              wdata_nxt = wdata_i;
              data_oe_nxt = 1'b1;
              oe_n_nxt = 1'b1;
              state_nxt = ST_WR_SET;
            end else begin
              cs_n_nxt = 1'b0;
              oe_n_nxt = 1'b0;
              we_n_nxt = 1'b1;
              state_nxt = ST_RD;
            end
          end
        end
        ST_RD: begin
          // wait the slowest of the three access paths plus the synchroniser
          cnt_nxt = cnt_r + cnt_t'(1);
          if (cnt_r == RD_LAST) begin
            rdata_nxt = data_s;
            rvalid_nxt = 1'b1;
            cs_n_nxt = 1'b1;
            oe_n_nxt = 1'b1;
            cnt_nxt = '0;
            state_nxt = ST_GAP;
          end
        end
        ST_WR_SET: begin
          // both strobes fall together, so the write starts here
          cs_n_nxt = 1'b0;
          we_n_nxt = 1'b0;
          state_nxt = ST_WR_PULSE;
        end
        ST_WR_PULSE: begin
          cnt_nxt = cnt_r + cnt_t'(1);
          if (cnt_r == WP_LAST) begin
            // both rise together: the device captures data on this edge
            cs_n_nxt = 1'b1;
            we_n_nxt = 1'b1;
            wdone_nxt = 1'b1;
            cnt_nxt = '0;
            state_nxt = ST_GAP;
          end
        end
        ST_GAP: begin
          // data held one cycle past the rising strobe, then released
          data_oe_nxt = 1'b0;
          cnt_nxt = cnt_r + cnt_t'(1);
          if (cnt_r == GAP_LAST) begin
            cnt_nxt = '0;
            state_nxt = ST_IDLE;
          end
        end
        ST_PROTECT: begin
          // writes stay blocked until the full recovery interval has run
          rec_cnt_nxt = rec_cnt_r + REC_W'(1);
          if (rec_cnt_r == REC_LAST) begin
            rec_cnt_nxt = '0;
            state_nxt = ST_IDLE;
          end
        end
        default: begin
          state_nxt = ST_PROTECT;
          cs_n_nxt = 1'b1;
          we_n_nxt = 1'b1;
          oe_n_nxt = 1'b1;
          data_oe_nxt = 1'b0;
        end
      endcase
    end
    ready_nxt = (state_nxt == ST_IDLE);
    protect_nxt = (state_nxt == ST_PROTECT);
  end

  // reset starts protected, since supply history is unknown
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_r <= ST_PROTECT;
      cnt_r <= '0;
      rec_cnt_r <= '0;
      addr_r <= '0;
      wdata_r <= '0;
      rdata_r <= '0;
      data_oe_r <= 1'b0;
      cs_n_r <= 1'b1;
      we_n_r <= 1'b1;
      oe_n_r <= 1'b1;
      ready_r <= 1'b0;
      rvalid_r <= 1'b0;
      wdone_r <= 1'b0;
      protect_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      rec_cnt_r <= rec_cnt_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      rdata_r <= rdata_nxt;
      data_oe_r <= data_oe_nxt;
      cs_n_r <= cs_n_nxt;
      we_n_r <= we_n_nxt;
      oe_n_r <= oe_n_nxt;
      ready_r <= ready_nxt;
      rvalid_r <= rvalid_nxt;
      wdone_r <= wdone_nxt;
      protect_r <= protect_nxt;
    end
  end

  // every output straight from a flop
  assign ready_o = ready_r;
  assign rdata_o = rdata_r;
  assign rvalid_o = rvalid_r;
  assign wdone_o = wdone_r;
  assign protect_o = protect_r;
  assign data_lines_o = wdata_r;
  assign data_oe_o = data_oe_r;
  assign addr_lines_o = addr_r;
  assign chip_select_n_o = cs_n_r;
  assign write_strobe_n_o = we_n_r;
  assign output_gate_n_o = oe_n_r;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);

  // address frozen while the write overlap is active
  addr_hold_a: assert property (
    (!cs_n_r && !we_n_r) |=> (cs_n_r || we_n_r || $stable(addr_r))
  ) else $error("address moved during write");

  // gate stays high whenever the strobe is low
  gate_in_write_a: assert property (
    !we_n_r |-> oe_n_r
  ) else $error("output gate low during write");

  // host never drives the data lines with the gate open
  no_contention_a: assert property (
    data_oe_r |-> oe_n_r
  ) else $error("data contention on data lines");

  // strobe held high through the recovery gap
  strobe_gap_a: assert property (
    $rose(we_n_r) |-> we_n_r [*4]
  ) else $error("strobe recovery gap too short");

  // write overlap lasts the full pulse with data driven
  write_pulse_a: assert property (
    $fell(we_n_r) |-> (!we_n_r && !cs_n_r && data_oe_r) [*8] ##1 (we_n_r && cs_n_r && data_oe_r)
  ) else $error("write pulse shape wrong");

  // strobes fall only after address and data were set up
  write_setup_a: assert property (
    $fell(cs_n_r) && !we_n_r |-> $past(data_oe_r) && $stable(addr_r)
  ) else $error("write began without setup");

  // read data taken only after the full access wait with enables low
  read_access_a: assert property (disable iff (!rstn_i || !pg_s)
    $fell(oe_n_r) |-> (!oe_n_r && !cs_n_r && we_n_r && !rvalid_r) [*8] ##1
      (!oe_n_r && !cs_n_r && we_n_r && !rvalid_r) [*5] ##1 rvalid_r
  ) else $error("read sampled at wrong time");

  // supply loss parks the pins in the cycle after the synchronised level is low
  protect_idle_a: assert property (
    !pg_s |=> (cs_n_r && we_n_r && oe_n_r && !data_oe_r && protect_r)
  ) else $error("pins active during supply loss");

  // protection ends only after the whole recovery count
  recovery_len_a: assert property (
    (protect_r && !protect_nxt) |-> (rec_cnt_r == REC_LAST) && pg_s
  ) else $error("protection left early");

endmodule : sram_host

`default_nettype wire

// File: test/sram_dev_model.sv
/*
  behavioural model of the battery-backed byte-wide static memory.
  assumes host pins wired straight in and a data wire resolved by the bench.
*/
`timescale 1ns/10ps
`default_nettype none

module sram_dev_model #(
  parameter int ACC_NS = 100,
  parameter int REC_NS = 100
) (
  input wire logic power_good_i,
  input wire logic [16:0] addr_i,
  input wire logic cs_n_i,
  input wire logic we_n_i,
  input wire logic oe_n_i,
  input wire logic [7:0] dq_i,
  output logic [7:0] dq_o,
  output logic dq_oe_o
);
  logic [7:0] mem [logic [16:0]];
  logic armed = 1'b0;
  logic blk = 1'b1;
  logic vld = 1'b0;
  logic [7:0] rd;
  wire logic wr_act = !cs_n_i && !we_n_i;

  // drive only in a read with good supply; a low strobe floats at once
  assign dq_oe_o = power_good_i && !cs_n_i && !oe_n_i && we_n_i;
  // re-read when a read opens, so a byte just written at the same address is seen
  always @(addr_i, wr_act, dq_oe_o) rd = mem.exists(addr_i) ? mem[addr_i] : 8'hff;
  // until the access time runs out the outputs show the inverse byte
  assign dq_o = vld ? rd : ~rd;
  always @(posedge dq_oe_o) begin
    #(ACC_NS);
    vld = dq_oe_o;
  end
  always @(negedge dq_oe_o) vld = 1'b0;

  // byte taken where the overlap of select and strobe ends
  always @(negedge wr_act) begin
    if (power_good_i && !blk) mem[addr_i] = dq_i;
  end
  // contents are lost on a supply drop only while still disarmed
  always @(negedge power_good_i) begin
    blk = 1'b1;
    if (!armed) mem.delete();
  end
  always @(posedge power_good_i) begin
    armed = 1'b1;
    #(REC_NS);
    blk = !power_good_i;
  end
endmodule : sram_dev_model

`default_nettype wire

// File: test/tb_top.sv
/*
  self-checking bench for the static memory host controller.
  assumes the device model beside it and a short recovery count.
*/
`timescale 1ns/10ps
`default_nettype none

module tb_top
  import sram_host_pkg::*;
;
  localparam int REC = 20;
  logic sys_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic req_i = 1'b0;
  logic write_i = 1'b0;
  logic [ADDR_W-1:0] addr_i = 17'h00000;
  logic [DATA_W-1:0] wdata_i = 8'h00;
  logic power_good_i = 1'b0;
  logic ready_o, rvalid_o, wdone_o, protect_o, data_oe_o, cs_n, we_n, oe_n, dev_oe;
  logic [DATA_W-1:0] rdata_o, data_lines_o, dev_q, dq, q;
  logic [DATA_W-1:0] idle_pat = 8'h55;
  logic [ADDR_W-1:0] addr_lines_o;
  int err_total = 0;
  int check_count = 0;
  int n;

  // an undriven wire shows a pattern that flips every cycle
  always @(posedge sys_clk_i) idle_pat <= ~idle_pat;
  assign dq = data_oe_o ? data_lines_o : (dev_oe ? dev_q : idle_pat);

  sram_host #(.RECOVERY_CYCLES(REC)) dut_u (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
    .req_i(req_i), .write_i(write_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .ready_o(ready_o), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .wdone_o(wdone_o),
    .protect_o(protect_o), .power_good_i(power_good_i), .data_lines_i(dq),
    .data_lines_o(data_lines_o), .data_oe_o(data_oe_o), .addr_lines_o(addr_lines_o),
    .chip_select_n_o(cs_n), .write_strobe_n_o(we_n), .output_gate_n_o(oe_n));
  sram_dev_model dev_u (.power_good_i(power_good_i), .addr_i(addr_lines_o),
    .cs_n_i(cs_n), .we_n_i(we_n), .oe_n_i(oe_n), .dq_i(dq), .dq_o(dev_q),
    .dq_oe_o(dev_oe));

  initial begin
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude

  task automatic tick();
    @(posedge sys_clk_i);
    #1;
  endtask : tick

  // one request; drop>0 pulls the supply away that many cycles after the take
  task automatic access(input logic wr, input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] d, input int drop);
    int k;
    k = 0;
    while (ready_o !== 1'b1 && k < 100) begin
      tick();
      k++;
    end
    req_i = 1'b1;
    write_i = wr;
    addr_i = a;
    wdata_i = d;
    tick();
    req_i = 1'b0;
    n = 0;
    while (n < 30 && (wr ? wdone_o : rvalid_o) !== 1'b1) begin
      tick();
      n++;
      if (n == drop) power_good_i = 1'b0;
      if (cs_n === 1'b0) chk("addr_lines", a, addr_lines_o);
      if (wr) chk("gate_n", 1, oe_n);
      chk("contention", 0, data_oe_o && dev_oe);
    end
    q = rdata_o;
  endtask : access

  task automatic t_reset();
    #1;
    chk("protect", 1, protect_o);
    chk("idle pins", 4'hc, {cs_n, we_n, data_oe_o, ready_o});
    rstn_i = 1'b1;
    power_good_i = 1'b1;
    n = 0;
    while (ready_o !== 1'b1 && n < 60) begin
      tick();
      n++;
    end
    chk("recovery wait", 1, n >= REC);
    chk("ready", 1, ready_o);
    chk("protect off", 0, protect_o);
    $display("t_reset done");
  endtask : t_reset

  task automatic t_wr_rd();
    logic [ADDR_W-1:0] av [3];
    logic [DATA_W-1:0] dv [3];
    av = '{17'h00000, 17'h1ffff, 17'h0aa55};
    dv = '{8'ha5, 8'h3c, 8'h5a};
    for (int i = 0; i < 3; i++) begin
      access(1'b1, av[i], dv[i], 0);
      chk("write cycles", 9, n);
      n = 0;
      while (ready_o !== 1'b1 && n < 20) begin
        tick();
        n++;
        chk("strobe gap", 1, we_n);
      end
      chk("gap cycles", 4, n);
    end
    for (int i = 0; i < 3; i++) begin
      access(1'b0, av[i], 8'h00, 0);
      chk("read cycles", 13, n);
      chk("read data", dv[i], q);
    end
    $display("t_wr_rd done");
  endtask : t_wr_rd

  task automatic t_power();
    access(1'b1, 17'h00100, 8'h11, 0);
    access(1'b1, 17'h00100, 8'h22, 3);
    chk("aborted write", 30, n);
    chk("idle pins", 4'he, {cs_n, we_n, oe_n, data_oe_o});
    chk("protect", 1, protect_o);
    req_i = 1'b1;
    repeat (5) begin
      tick();
      chk("refused select", 1, cs_n);
    end
    req_i = 1'b0;
    power_good_i = 1'b1;
    access(1'b0, 17'h00100, 8'h00, 0);
    chk("retained", 8'h11, q);
    chk("protect off", 0, protect_o);
    $display("t_power done");
  endtask : t_power

  initial begin
    repeat (4) @(posedge sys_clk_i);
    t_reset();
    t_wr_rd();
    t_power();
    conclude();
  end

  // the whole run needs well under a thousand cycles
  initial begin
    #20000;
    err_total++;
    conclude();
  end
endmodule : tb_top

`default_nettype wire
